// *** core/sdr_pkg.sv ***
// Constants and carrier types for the step-down regulator control
// How it works
// - Main control holds a 5-bit voltage code, 50 mV steps from 0.6 V.
// - Span bit picks low or high span; enabled code changes stay in span.
// - Span bit changes only while disabled; host disables before changing.
// - Written code outside the chosen span is replaced by the 1.3 V code.
// - Writing enable starts the regulator; switching begins about 3 ms later.
// - Soft start uses the reduced peak current limit.
// - Both switches idle for a delay after zero current enters power saving.
// - Ramping steps the applied code one count toward target every 4 ms.
// - Ramping stays inside the current span while enabled.
// - Two-bit ramp field turns controlled ramping on or off.
// - Over-current turns high side off until the off-time expires.
// - Over-current sets its event bit and toggles the fault flag.
// - Over-current with output 400 mV low sets the under-voltage event.
// - Under-voltage detection is masked during startup.
// - Per-fault trigger bits start a power-cycle with programmable wait.
// - Over-voltage: high side off, discharge on, event set, flag toggled.
// - After over-voltage stay off and pulled down until cleared.
// - One bit enables discharge during the power-cycle wait after a fault; over-voltage hold discharges regardless.
// - Another bit enables discharge when disabled through the enable bit.
// - Flag toggles once per event until the host reads and clears it.
package sdr_pkg;
  // Register offsets
  localparam logic [7:0] FAULT_EV_ADDR  = 8'h06;
  localparam logic [7:0] PCYC_CFG_ADDR  = 8'h13;
  localparam logic [7:0] MAIN_CTRL_ADDR = 8'h30;
  localparam logic [7:0] DISCH_CFG_ADDR = 8'h31;
  localparam logic [7:0] RAMP_CFG_ADDR  = 8'h50;
  // Fields
  localparam int CODE_W      = 5;
  localparam int CODE_MSB    = 4;
  localparam int SPAN_BIT    = 6;
  localparam int EN_BIT      = 7;
  localparam int EV_OC_BIT   = 0;
  localparam int EV_OV_BIT   = 1;
  localparam int EV_UV_BIT   = 2;
  localparam int DIS_FLT_BIT = 4;
  localparam int DIS_OFF_BIT = 5;
  localparam int PC_OC_BIT   = 0;
  localparam int PC_UV_BIT   = 1;
  localparam int PC_OV_BIT   = 2;
  localparam int PC_WAIT_LSB = 4;
  localparam int PC_WAIT_MSB = 7;
  localparam logic [4:0] MID_CODE = 5'h0e;
  localparam logic [7:0] DISCH_MASK = 8'h30;
  // Reset values
  localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] DISCH_CFG_RST = 8'h00;
  localparam logic [1:0] RAMP_CFG_RST  = 2'h0;
  localparam logic [7:0] PCYC_CFG_RST  = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int MS_NS           = 1000000;
  localparam int MS_TICK_CYCLES  = MS_NS / CLK_PERIOD_NS;
  localparam int START_DELAY_MS  = 3;
  localparam int SOFT_START_MS   = 2;
  localparam int RAMP_STEP_MS    = 4;
  localparam int PSAVE_DELAY_CYC = 8;

  typedef enum logic [2:0] {ST_OFF, ST_DELAY, ST_SOFT, ST_RUN, ST_OVHOLD, ST_PCYC} sdr_state_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sdr_reg_req_type;

  typedef struct packed {
    logic oc_detect;
    logic uv_detect;
    logic ov_detect;
    logic offtime_done;
    logic zero_cross;
    logic switches_idle;
  } sdr_sense_type;

  typedef struct packed {
    logic switching_en;
    logic hs_allow;
    logic soft_limit;
    logic power_save;
    logic discharge_on;
  } sdr_stage_type;
endpackage

// *** core/sdr_tick_div.sv ***
// One-cycle enable pulse every CYCLES clocks
`timescale 1ns/10ps
module sdr_tick_div
  import sdr_pkg::*;
#(
  parameter int CYCLES = MS_TICK_CYCLES
)(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Tick
  output logic      tick
);
  localparam int CW = $clog2(CYCLES + 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } sdr_div_type;
  sdr_div_type s_ff;
  sdr_div_type nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.tick = (s_ff.cnt == CW'(CYCLES - 1));
    nxt_s.cnt = nxt_s.tick ? '0 : CW'(s_ff.cnt + 1'b1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign tick = s_ff.tick;
endmodule

// *** core/sdr_ramp.sv ***
// Applied voltage code sequencer
`timescale 1ns/10ps
module sdr_ramp
  import sdr_pkg::*;
#(
  parameter int STEP_TICKS = RAMP_STEP_MS
)(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Control
  input  wire logic              ms_tick,
  input  wire logic              ramp_on,
  input  wire logic [CODE_W-1:0] target,
  // Result
  output logic [CODE_W-1:0]      applied
);
  typedef struct packed {
    logic [3:0]        cnt;
    logic [CODE_W-1:0] applied;
  } sdr_ramp_type;
  sdr_ramp_type s_ff;
  sdr_ramp_type nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    if (!ramp_on)
    begin
      nxt_s.applied = target;
      nxt_s.cnt = '0;
    end
    else if (s_ff.applied == target)
      nxt_s.cnt = '0;
    else if (ms_tick)
    begin
      if (s_ff.cnt == 4'(STEP_TICKS - 1))
      begin
        nxt_s.cnt = '0;
        // Target is already clamped to the span, so steps stay in it
        if (s_ff.applied < target)
          nxt_s.applied = CODE_W'(s_ff.applied + 1'b1);
        else
          nxt_s.applied = CODE_W'(s_ff.applied - 1'b1);
      end
      else
        nxt_s.cnt = 4'(s_ff.cnt + 1'b1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign applied = s_ff.applied;

  a_ramp_one_step: assert property (@(posedge sys_clk) disable iff (rst)
    (ramp_on && $past(ramp_on)) |-> (CODE_W'(s_ff.applied - $past(s_ff.applied)) inside
    {5'h00, 5'h01, 5'h1f}))
    else $error("ramp moved more than one code");
  a_ramp_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (ramp_on && s_ff.applied == target) ##1 (ramp_on && $stable(target))
    |-> s_ff.applied == target)
    else $error("ramp left a reached target");
  c_ramp_step: cover property (@(posedge sys_clk) disable iff (rst)
    ramp_on && $changed(s_ff.applied));
endmodule

// *** core/sdr_stepdown_ctrl.sv ***
// Step-down regulator control: registers, sequencing, fault handling
`timescale 1ns/10ps
module sdr_stepdown_ctrl
  import sdr_pkg::*;
#(
  parameter int MS_CYCLES = MS_TICK_CYCLES
)(
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst,
  // Register port
  input  wire sdr_reg_req_type reg_req,
  output logic [7:0]           reg_rdata,
  output logic                 reg_rvalid,
  // Power stage comparators and commands
  input  wire sdr_sense_type   sense,
  output sdr_stage_type        stage,
  output logic [CODE_W-1:0]    applied_code,
  output logic                 upper_span_select,
  output logic                 system_fault_flag
);
  typedef struct packed {
    sdr_state_type st;
    logic [3:0]    tcnt;
    logic [7:0]    main_ctrl;
    logic [7:0]    disch_cfg;
    logic [1:0]    ramp_cfg;
    logic [7:0]    pcyc_cfg;
    logic [2:0]    ev;
    logic          flag;
    logic          hs_off;
    logic [3:0]    idle_cnt;
    logic [7:0]    rdata;
    logic          rvalid;
    sdr_stage_type stage;
  } sdr_core_type;

  sdr_core_type      s_ff;
  sdr_core_type      nxt_s;
  logic              ms_tick;
  logic              ramp_on;
  logic [CODE_W-1:0] ramp_code;

  sdr_tick_div #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (ms_tick)
  );

  // Ramp only once started, so a fresh span is applied directly
  assign ramp_on = s_ff.main_ctrl[EN_BIT] && (s_ff.ramp_cfg != 2'h0)
    && (s_ff.st == ST_DELAY || s_ff.st == ST_SOFT || s_ff.st == ST_RUN);

  sdr_ramp #(
    .STEP_TICKS (RAMP_STEP_MS)
  ) u_ramp (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ms_tick (ms_tick),
    .ramp_on (ramp_on),
    .target  (s_ff.main_ctrl[CODE_MSB:0]),
    .applied (ramp_code)
  );

  always_comb
  begin
    logic [2:0]        ev_set;
    logic [2:0]        ev_base;
    logic [CODE_W-1:0] code;
    logic              span;
    logic              en;
    logic              active;
    logic              n_active;
    logic              pc_trig;
    ev_set = '0;
    ev_base = '0;
    code = '0;
    span = 1'b0;
    en = s_ff.main_ctrl[EN_BIT];
    active = (s_ff.st == ST_SOFT) || (s_ff.st == ST_RUN);
    n_active = 1'b0;
    pc_trig = 1'b0;
    nxt_s = s_ff;
    nxt_s.rvalid = 1'b0;

    // Span frozen while enabled
    span = en ? s_ff.main_ctrl[SPAN_BIT] : reg_req.wdata[SPAN_BIT];
    code = reg_req.wdata[CODE_MSB:0];
    if ((!span && code > MID_CODE) || (span && code < MID_CODE))
      code = MID_CODE;

    // Fault detection
    ev_set[EV_OC_BIT] = active && sense.oc_detect;
    ev_set[EV_OV_BIT] = active && sense.ov_detect;
    ev_set[EV_UV_BIT] = (s_ff.st == ST_RUN) && sense.oc_detect && sense.uv_detect;
    ev_base = (reg_req.rd && reg_req.addr == FAULT_EV_ADDR) ? 3'h0 : s_ff.ev;
    pc_trig = (ev_set[EV_OC_BIT] && s_ff.pcyc_cfg[PC_OC_BIT])
           || (ev_set[EV_UV_BIT] && s_ff.pcyc_cfg[PC_UV_BIT]);

    // Register writes
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        MAIN_CTRL_ADDR: nxt_s.main_ctrl = {reg_req.wdata[EN_BIT], span, 1'b0, code};
        DISCH_CFG_ADDR: nxt_s.disch_cfg = reg_req.wdata & DISCH_MASK;
        RAMP_CFG_ADDR:  nxt_s.ramp_cfg = reg_req.wdata[1:0];
        PCYC_CFG_ADDR:  nxt_s.pcyc_cfg = reg_req.wdata;
        default:        nxt_s.pcyc_cfg = s_ff.pcyc_cfg;
      endcase
    end

    // Register reads, unmapped reads return zero
    if (reg_req.rd)
    begin
      nxt_s.rvalid = 1'b1;
      case (reg_req.addr)
        FAULT_EV_ADDR:  nxt_s.rdata = {5'h00, s_ff.ev};
        MAIN_CTRL_ADDR: nxt_s.rdata = s_ff.main_ctrl;
        DISCH_CFG_ADDR: nxt_s.rdata = s_ff.disch_cfg;
        RAMP_CFG_ADDR:  nxt_s.rdata = {6'h00, s_ff.ramp_cfg};
        PCYC_CFG_ADDR:  nxt_s.rdata = s_ff.pcyc_cfg;
        default:        nxt_s.rdata = 8'h00;
      endcase
    end

    // Read clears, a new event wins and toggles once
    nxt_s.ev = ev_base | ev_set;
    if (|(ev_set & ~ev_base))
      nxt_s.flag = !s_ff.flag;

    // High side held off until the off-time ends
    if (ev_set[EV_OC_BIT])
      nxt_s.hs_off = 1'b1;
    else if (sense.offtime_done || !active)
      nxt_s.hs_off = 1'b0;

    // Sequencer
    unique case (s_ff.st)
      ST_OFF:
      begin
        nxt_s.tcnt = '0;
        if (en)
          nxt_s.st = ST_DELAY;
      end
      ST_DELAY:
      begin
        if (ms_tick)
        begin
          nxt_s.tcnt = 4'(s_ff.tcnt + 1'b1);
          if (s_ff.tcnt == 4'(START_DELAY_MS - 1))
          begin
            nxt_s.st = ST_SOFT;
            nxt_s.tcnt = '0;
          end
        end
      end
      ST_SOFT:
      begin
        if (ms_tick)
        begin
          nxt_s.tcnt = 4'(s_ff.tcnt + 1'b1);
          if (s_ff.tcnt == 4'(SOFT_START_MS - 1))
          begin
            nxt_s.st = ST_RUN;
            nxt_s.tcnt = '0;
          end
        end
      end
      ST_RUN:
        nxt_s.tcnt = '0;
      ST_OVHOLD:
      begin
        // Leaves only after the event is read and the output is back down
        nxt_s.tcnt = '0;
        if (!ev_base[EV_OV_BIT] && !sense.ov_detect)
          nxt_s.st = s_ff.pcyc_cfg[PC_OV_BIT] ? ST_PCYC : ST_OFF;
      end
      ST_PCYC:
      begin
        if (ms_tick)
        begin
          nxt_s.tcnt = 4'(s_ff.tcnt + 1'b1);
          if (s_ff.tcnt >= s_ff.pcyc_cfg[PC_WAIT_MSB:PC_WAIT_LSB])
          begin
            nxt_s.st = en ? ST_DELAY : ST_OFF;
            nxt_s.tcnt = '0;
          end
        end
      end
    endcase

    // Fault and disable overrides
    if (ev_set[EV_OV_BIT])
      nxt_s.st = ST_OVHOLD;
    else if (pc_trig)
    begin
      nxt_s.st = ST_PCYC;
      nxt_s.tcnt = '0;
    end
    else if (!en && s_ff.st != ST_OVHOLD && s_ff.st != ST_PCYC)
      nxt_s.st = ST_OFF;

    // Light-load idle counting after zero crossing
    if (nxt_s.st == ST_RUN && sense.switches_idle && (s_ff.idle_cnt != 4'h0 || sense.zero_cross))
    begin
      if (s_ff.idle_cnt != 4'(PSAVE_DELAY_CYC))
        nxt_s.idle_cnt = 4'(s_ff.idle_cnt + 1'b1);
    end
    else
      nxt_s.idle_cnt = '0;

    // Power stage commands
    n_active = (nxt_s.st == ST_SOFT) || (nxt_s.st == ST_RUN);
    nxt_s.stage.switching_en = n_active;
    nxt_s.stage.hs_allow = n_active && !nxt_s.hs_off;
    nxt_s.stage.soft_limit = (nxt_s.st == ST_SOFT);
    nxt_s.stage.power_save = (nxt_s.idle_cnt == 4'(PSAVE_DELAY_CYC));
    nxt_s.stage.discharge_on = (nxt_s.st == ST_OVHOLD)
      || (nxt_s.st == ST_PCYC && s_ff.disch_cfg[DIS_FLT_BIT])
      || (nxt_s.st == ST_OFF && !en && s_ff.disch_cfg[DIS_OFF_BIT]);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_ff <= '0;
      s_ff.st <= ST_OFF;
      s_ff.main_ctrl <= MAIN_CTRL_RST;
      s_ff.disch_cfg <= DISCH_CFG_RST;
      s_ff.ramp_cfg <= RAMP_CFG_RST;
      s_ff.pcyc_cfg <= PCYC_CFG_RST;
    end
    else
      s_ff <= nxt_s;
  end

  assign reg_rdata = s_ff.rdata;
  assign reg_rvalid = s_ff.rvalid;
  assign stage = s_ff.stage;
  assign applied_code = ramp_code;
  assign upper_span_select = s_ff.main_ctrl[SPAN_BIT];
  assign system_fault_flag = s_ff.flag;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_oc_hs_off: assert property (
    ((s_ff.st == ST_SOFT || s_ff.st == ST_RUN) && sense.oc_detect) |=> !stage.hs_allow)
    else $error("high side not cut on over-current");
  a_oc_event_set: assert property (
    ((s_ff.st == ST_SOFT || s_ff.st == ST_RUN) && sense.oc_detect) |=> s_ff.ev[EV_OC_BIT])
    else $error("over-current event not latched");
  a_uv_start_mask: assert property (
    ((s_ff.st == ST_DELAY || s_ff.st == ST_SOFT) && !s_ff.ev[EV_UV_BIT])
    |=> !s_ff.ev[EV_UV_BIT])
    else $error("under-voltage raised during startup");
  a_ov_pulldown: assert property (
    ((s_ff.st == ST_SOFT || s_ff.st == ST_RUN) && sense.ov_detect)
    |=> (s_ff.st == ST_OVHOLD && stage.discharge_on && !stage.hs_allow && s_ff.ev[EV_OV_BIT]))
    else $error("over-voltage response missing");
  a_flag_no_retoggle: assert property (
    ((s_ff.ev == 3'h7 || (s_ff.ev[EV_OC_BIT] && !sense.uv_detect && !sense.ov_detect))
     && !(reg_req.rd && reg_req.addr == FAULT_EV_ADDR)) |=> $stable(s_ff.flag))
    else $error("fault flag toggled twice for one event");
  a_span_locked: assert property (
    s_ff.main_ctrl[EN_BIT] |=> $stable(s_ff.main_ctrl[SPAN_BIT]))
    else $error("span changed while enabled");
  a_code_in_span: assert property (
    (reg_req.wr && reg_req.addr == MAIN_CTRL_ADDR)
    |=> (s_ff.main_ctrl[SPAN_BIT] ? s_ff.main_ctrl[CODE_MSB:0] >= MID_CODE
                                  : s_ff.main_ctrl[CODE_MSB:0] <= MID_CODE))
    else $error("code left its span");
  a_pcyc_trigger: assert property (
    (s_ff.st == ST_RUN && sense.oc_detect && !sense.ov_detect && s_ff.pcyc_cfg[PC_OC_BIT])
    |=> (s_ff.st == ST_PCYC && !stage.switching_en))
    else $error("power-cycle not started");
  a_soft_limit: assert property (
    stage.soft_limit |-> (s_ff.st == ST_SOFT && stage.switching_en))
    else $error("soft limit outside soft start");
  a_off_discharge: assert property (
    (s_ff.main_ctrl[EN_BIT] && reg_req.wr && reg_req.addr == MAIN_CTRL_ADDR
     && !reg_req.wdata[EN_BIT] && s_ff.disch_cfg[DIS_OFF_BIT] && s_ff.disch_cfg[DIS_FLT_BIT])
    |=> ##1 stage.discharge_on)
    else $error("no discharge after disable");
  a_start_delay: assert property (
    (s_ff.st == ST_DELAY && s_ff.tcnt != 4'(START_DELAY_MS - 1)) |=> !stage.switching_en)
    else $error("switching before the start delay");
  a_delay_to_soft: assert property (
    (s_ff.st == ST_DELAY && s_ff.main_ctrl[EN_BIT] && ms_tick
     && s_ff.tcnt == 4'(START_DELAY_MS - 1)) |=> (stage.switching_en && stage.soft_limit))
    else $error("start delay did not end in soft start");
  a_soft_hold: assert property (
    (s_ff.st == ST_SOFT && s_ff.main_ctrl[EN_BIT] && !ms_tick && !sense.oc_detect
     && !sense.ov_detect) |=> stage.soft_limit)
    else $error("soft limit dropped early");
  a_en_off: assert property (
    (!s_ff.main_ctrl[EN_BIT] && s_ff.st != ST_OVHOLD && s_ff.st != ST_PCYC)
    |=> !stage.switching_en)
    else $error("switching while disabled");
  a_hs_restore: assert property (
    (s_ff.st == ST_RUN && s_ff.main_ctrl[EN_BIT] && sense.offtime_done && !sense.oc_detect
     && !sense.ov_detect) |=> stage.hs_allow)
    else $error("high side not back after off-time");
  a_flag_new_event: assert property (
    ((s_ff.st == ST_SOFT || s_ff.st == ST_RUN) && sense.oc_detect && !s_ff.ev[EV_OC_BIT])
    |=> $changed(s_ff.flag))
    else $error("fault flag not toggled");
  a_uv_event_set: assert property (
    (s_ff.st == ST_RUN && sense.oc_detect && sense.uv_detect) |=> s_ff.ev[EV_UV_BIT])
    else $error("under-voltage event not latched");
  a_ov_hold: assert property (
    (s_ff.st == ST_OVHOLD && s_ff.ev[EV_OV_BIT]
     && !(reg_req.rd && reg_req.addr == FAULT_EV_ADDR))
    |=> (s_ff.st == ST_OVHOLD && stage.discharge_on && !stage.switching_en))
    else $error("left over-voltage hold before clear");
  a_pcyc_disch_on: assert property (
    (s_ff.st == ST_PCYC && !ms_tick && s_ff.disch_cfg[DIS_FLT_BIT]) |=> stage.discharge_on)
    else $error("no discharge during power-cycle");
  a_pcyc_disch_off: assert property (
    (s_ff.st == ST_PCYC && !ms_tick && !s_ff.disch_cfg[DIS_FLT_BIT]) |=> !stage.discharge_on)
    else $error("discharge during power-cycle while off");
  a_psave_delay: assert property (
    $rose(stage.power_save) |-> $past(s_ff.idle_cnt) == 4'(PSAVE_DELAY_CYC - 1))
    else $error("power saving entered without the idle delay");
  a_psave_exit: assert property (
    (stage.power_save && !sense.switches_idle) |=> !stage.power_save)
    else $error("power saving kept after switching resumed");
  a_ramp_direct: assert property (
    !ramp_on |=> applied_code == $past(s_ff.main_ctrl[CODE_MSB:0]))
    else $error("code not applied directly");
  a_ramp_in_span: assert property (
    ramp_on |-> (s_ff.main_ctrl[SPAN_BIT] ? applied_code >= MID_CODE
                                          : applied_code <= MID_CODE))
    else $error("ramp left its span");

  c_start_run: cover property (s_ff.st == ST_SOFT ##1 s_ff.st == ST_RUN);
  c_ov_hold: cover property (s_ff.st == ST_OVHOLD ##1 s_ff.st != ST_OVHOLD);
  c_pcyc_restart: cover property (s_ff.st == ST_PCYC ##1 s_ff.st == ST_DELAY);
  c_power_save: cover property ($rose(stage.power_save));
endmodule

// *** verif/sdr_stage_model.sv ***
// Behavioural power stage and comparators facing the regulator control
`timescale 1ns/10ps
module sdr_stage_model
  import sdr_pkg::*;
#(
  parameter int OFF_CYC = 4
)(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // Commands from the control
  input  wire sdr_stage_type stage,
  // Requests from the bench
  input  wire logic          oc_req,
  input  wire logic          uv_req,
  input  wire logic          ov_req,
  input  wire logic          light_load,
  // Comparator outputs
  output sdr_sense_type      sense
);
  int off_cnt;

  // Constant off-timer, runs while the high side is held off
  always_ff @(posedge sys_clk)
  begin
    if (rst || stage.hs_allow)
      off_cnt <= 0;
    else if (off_cnt < OFF_CYC)
      off_cnt <= off_cnt + 1;
  end

  // Current only flows while switching
  always_comb
  begin
    sense.oc_detect     = oc_req & stage.switching_en;
    sense.uv_detect     = uv_req & stage.switching_en;
    sense.ov_detect     = ov_req;
    sense.offtime_done  = (off_cnt == OFF_CYC);
    sense.zero_cross    = light_load & stage.switching_en;
    sense.switches_idle = light_load & stage.switching_en;
  end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the step-down regulator control
`timescale 1ns/10ps
module testbench
  import sdr_pkg::*;
;
  logic                  sys_clk;
  logic                  rst;
  sdr_reg_req_type       reg_req;
  logic [7:0]            reg_rdata;
  logic                  reg_rvalid;
  sdr_sense_type         sense;
  sdr_stage_type         stage;
  logic [CODE_W-1:0]     applied_code;
  logic                  upper_span_select;
  logic                  system_fault_flag;
  logic                  oc_req;
  logic                  uv_req;
  logic                  ov_req;
  logic                  light_load;
  int                    err_total;
  int                    num_checks;

  sdr_stepdown_ctrl #(.MS_CYCLES(10)) u_sdr_stepdown_ctrl (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sense(sense), .stage(stage), .applied_code(applied_code),
    .upper_span_select(upper_span_select), .system_fault_flag(system_fault_flag));

  sdr_stage_model u_sdr_stage_model (
    .sys_clk(sys_clk), .rst(rst), .stage(stage), .oc_req(oc_req), .uv_req(uv_req),
    .ov_req(ov_req), .light_load(light_load), .sense(sense));

  always #20 sys_clk = ~sys_clk;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    if (got !== exp)
      err_total++;
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge sys_clk);
    reg_req.rd = 1'b0;
    chk1(reg_rvalid, 1'b1, "read valid");
    chk8(reg_rdata, exp, "read data");
  endtask

  task automatic pulse_oc(input logic uv);
    @(negedge sys_clk);
    oc_req = 1'b1;
    uv_req = uv;
    @(negedge sys_clk);
    oc_req = 1'b0;
    uv_req = 1'b0;
  endtask

  task automatic wait_sw(input logic v, input int n);
    for (int i = 0; i < n && stage.switching_en !== v; i++) @(negedge sys_clk);
    chk1(stage.switching_en, v, "switching");
  endtask

  // Reset values and unmapped offset
  task automatic t_reset();
    rd(MAIN_CTRL_ADDR, 8'h00);
    rd(DISCH_CFG_ADDR, 8'h00);
    rd(RAMP_CFG_ADDR, 8'h00);
    rd(PCYC_CFG_ADDR, 8'h00);
    rd(FAULT_EV_ADDR, 8'h00);
    wr(8'h7f, 8'hff);
    rd(8'h7f, 8'h00);
    chk8({3'h0, stage}, 8'h00, "stage idle");
  endtask

  // Span clamping while disabled
  task automatic t_span();
    logic [7:0] wv[6] = '{8'h0f, 8'h4d, 8'h4f, 8'h15, 8'h5f, 8'h25};
    logic [7:0] ev[6] = '{8'h0e, 8'h4e, 8'h4f, 8'h0e, 8'h5f, 8'h05};
    for (int i = 0; i < 6; i++)
    begin
      wr(MAIN_CTRL_ADDR, wv[i]);
      rd(MAIN_CTRL_ADDR, ev[i]);
      chk1(upper_span_select, ev[i][6], "span");
    end
  endtask

  // Start delay, soft start, masked under-voltage, locked span
  task automatic t_start();
    wr(MAIN_CTRL_ADDR, 8'h85);
    cyc(15);
    chk1(stage.switching_en, 1'b0, "early start");
    wait_sw(1'b1, 40);
    chk1(stage.soft_limit, 1'b1, "soft limit");
    pulse_oc(1'b1);
    rd(FAULT_EV_ADDR, 8'h01);
    for (int i = 0; i < 30 && stage.soft_limit !== 1'b0; i++) @(negedge sys_clk);
    chk1(stage.soft_limit, 1'b0, "soft end");
    wr(MAIN_CTRL_ADDR, 8'hc5);
    rd(MAIN_CTRL_ADDR, 8'h85);
    wr(MAIN_CTRL_ADDR, 8'h8f);
    rd(MAIN_CTRL_ADDR, 8'h8e);
    cyc(2);
    chk8({3'h0, applied_code}, 8'h0e, "direct code");
    wr(MAIN_CTRL_ADDR, 8'h85);
  endtask

  // Over-current, under-voltage, single flag toggle
  task automatic t_oc();
    logic f;
    f = system_fault_flag;
    pulse_oc(1'b0);
    cyc(1);
    chk1(stage.hs_allow, 1'b0, "high side off");
    chk1(system_fault_flag, ~f, "flag toggle");
    pulse_oc(1'b0);
    cyc(1);
    chk1(system_fault_flag, ~f, "no retoggle");
    rd(FAULT_EV_ADDR, 8'h01);
    rd(FAULT_EV_ADDR, 8'h00);
    pulse_oc(1'b1);
    rd(FAULT_EV_ADDR, 8'h05);
    for (int i = 0; i < 10 && stage.hs_allow !== 1'b1; i++) @(negedge sys_clk);
    chk1(stage.hs_allow, 1'b1, "high side back");
  endtask

  // Controlled ramping up, hold, down, then direct
  task automatic t_ramp();
    wr(RAMP_CFG_ADDR, 8'h01);
    wr(MAIN_CTRL_ADDR, 8'h88);
    for (int i = 0; i < 45 && applied_code === 5'h05; i++) @(negedge sys_clk);
    chk8({3'h0, applied_code}, 8'h06, "first step");
    cyc(30);
    chk8({3'h0, applied_code}, 8'h06, "step spacing");
    for (int i = 0; i < 15 && applied_code === 5'h06; i++) @(negedge sys_clk);
    chk8({3'h0, applied_code}, 8'h07, "second step");
    cyc(150);
    chk8({3'h0, applied_code}, 8'h08, "hold target");
    wr(RAMP_CFG_ADDR, 8'h03);
    wr(MAIN_CTRL_ADDR, 8'h87);
    for (int i = 0; i < 45 && applied_code === 5'h08; i++) @(negedge sys_clk);
    chk8({3'h0, applied_code}, 8'h07, "down step");
    wr(RAMP_CFG_ADDR, 8'h00);
    wr(MAIN_CTRL_ADDR, 8'h8a);
    cyc(2);
    chk8({3'h0, applied_code}, 8'h0a, "ramp off");
  endtask

  // Light load power saving
  task automatic t_psave();
    light_load = 1'b1;
    cyc(5);
    chk1(stage.power_save, 1'b0, "save too early");
    cyc(7);
    chk1(stage.power_save, 1'b1, "power save");
    light_load = 1'b0;
    cyc(3);
    chk1(stage.power_save, 1'b0, "save exit");
  endtask

  // Over-voltage hold with fault discharge
  task automatic t_ov();
    logic f;
    wr(DISCH_CFG_ADDR, 8'h10);
    f = system_fault_flag;
    @(negedge sys_clk);
    ov_req = 1'b1;
    cyc(2);
    chk1(stage.switching_en, 1'b0, "ov off");
    chk1(stage.discharge_on, 1'b1, "ov discharge");
    chk1(system_fault_flag, ~f, "ov flag");
    ov_req = 1'b0;
    cyc(10);
    chk1(stage.discharge_on, 1'b1, "ov held");
    rd(FAULT_EV_ADDR, 8'h02);
    wait_sw(1'b1, 60);
    chk1(stage.discharge_on, 1'b0, "ov released");
  endtask

  // Power-cycle on over-current, then disable with discharge
  task automatic t_pcyc();
    for (int i = 0; i < 30 && stage.soft_limit !== 1'b0; i++) @(negedge sys_clk);
    wr(PCYC_CFG_ADDR, 8'h11);
    pulse_oc(1'b0);
    cyc(10);
    chk1(stage.switching_en, 1'b0, "cycle off");
    chk1(stage.discharge_on, 1'b1, "cycle discharge");
    wait_sw(1'b1, 90);
    rd(FAULT_EV_ADDR, 8'h01);
    wr(PCYC_CFG_ADDR, 8'h00);
    wr(DISCH_CFG_ADDR, 8'h30);
    rd(DISCH_CFG_ADDR, 8'h30);
    wr(MAIN_CTRL_ADDR, 8'h0a);
    cyc(3);
    chk1(stage.switching_en, 1'b0, "disabled");
    chk1(stage.discharge_on, 1'b1, "off discharge");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #(40 * 20000);
    err_total++;
    end_of_test();
  end

  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    reg_req = '0;
    oc_req = 1'b0;
    uv_req = 1'b0;
    ov_req = 1'b0;
    light_load = 1'b0;
    err_total = 0;
    num_checks = 0;
    cyc(20);
    rst = 1'b0;
    t_reset();
    t_span();
    t_start();
    t_oc();
    t_ramp();
    t_psave();
    t_ov();
    t_pcyc();
    end_of_test();
  end
endmodule
